// ===== bench/board_model.sv
// Purpose: Board logic that drives the clock pin, sleep pin and pads
// Assumes: Bench sets wanted levels; device drive wins on I/O pins
// Notes:   A released pad shows the inverse of its last driven level

`timescale 1ns/1ns

module board_model (
   input  wire logic       clock,     // System clock
   input  wire logic       sleep_set, // Wanted sleep level
   input  wire logic [7:0] in_val,    // Wanted input levels
   input  wire logic [7:0] in_drv,    // Board drives input pin
   input  wire logic [7:0] io_val,    // Wanted I/O levels
   input  wire logic [7:0] io_drv,    // Board drives I/O pin
   input  wire logic [7:0] pad_out,   // Device pin drive
   input  wire logic [7:0] pad_oe,    // Device pin enable
   output logic            dev_clk,   // Common clock pin
   output logic            sleep_pin, // Sleep request pin
   output logic [7:0]      in_pad,    // Input wires
   output logic [7:0]      io_pad     // I/O wires
);
   logic [7:0] in_last = 8'h00; // Last driven input levels
   logic [7:0] io_last = 8'h00; // Last driven I/O levels
   logic [7:0] io_on;           // Someone drives the I/O wire

   initial dev_clk = 1'b0;
   initial sleep_pin = 1'b0;

   // -------------------------------------------------------------
   // Pins
   // -------------------------------------------------------------
   // Sleep pin follows the bench at the clock edge
   always @(posedge clock) sleep_pin <= sleep_set;

   // Wire levels; a floating wire must not look like the kept level
   assign io_on  = pad_oe | io_drv;
   assign in_pad = (in_drv & in_val) | (~in_drv & ~in_last);
   assign io_pad = (pad_oe & pad_out) | (~pad_oe & io_drv & io_val) |
                   (~io_on & ~io_last);

   // Remember what was last driven on each wire
   always @(posedge clock) begin
      in_last <= (in_drv & in_pad) | (~in_drv & in_last);
      io_last <= (io_on & io_pad) | (~io_on & io_last);
   end

   // One clock burst; the pin stands low between bursts
   task automatic edge_pulse();
      @(posedge clock) dev_clk <= 1'b1;
      repeat (2) @(posedge clock);
      dev_clk <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the power, reset and hold block
// Assumes: Default sizes of eight cells and eight inputs
// Notes:   Expected pin values come from a small register model

`timescale 1ns/1ns

module tb_top;
   import pld_hold_pkg::*;

   logic        clock = 1'b0, rst = 1'b1, supply_ok = 1'b1;
   logic        opt_en = 1'b1, oe_n = 1'b0, sleep_set = 1'b0;
   logic [7:0]  cell_reg = 8'h0f, reg_next = 8'h00, comb_value = 8'h00;
   logic [7:0]  comb_enable = 8'h00, in_val = 8'h00, in_drv = 8'hff;
   logic [7:0]  io_val = 8'h00, io_drv = 8'hff, pl_mask = 8'h00;
   logic [7:0]  pl_val = 8'h00;
   logic [4:0]  pv = 5'h00;    // preload, verify, lock, write, read
   logic [63:0] sig_wdata = 64'h0;
   logic [7:0]  io_pad_out, io_pad_oe, verify_data, in_pad, io_pad;
   logic [15:0] array_in, snap, keep;
   logic [63:0] sig_data;
   logic        spare_input, sleeping, settling, locked, verify_valid;
   logic        verify_refused, preload_refused, sig_valid, dev_clk;
   logic        sleep_pin;
   logic [7:0]  m_reg = 8'h00; // Register model
   logic [63:0] m_sig = 64'h0; // Signature model
   logic        m_lock = 1'b0;
   int          seed = 82, error_cnt = 0, cmp_count = 0;

   initial forever #10 clock = ~clock;

   pld_power_reset_hold_control dut_u (
      .clock(clock), .rst(rst), .supply_ok(supply_ok),
      .sleep_option_en(opt_en), .sleep_request_pin(sleep_pin),
      .dev_clk_pin(dev_clk), .oe_n_pin(oe_n), .cell_registered(cell_reg),
      .reg_next(reg_next), .comb_value(comb_value),
      .comb_enable(comb_enable), .in_pad(in_pad), .in_ext_drive(in_drv),
      .io_pad_in(io_pad), .io_ext_drive(io_drv), .preload_strobe(pv[0]),
      .preload_mask(pl_mask), .preload_value(pl_val), .verify_req(pv[1]),
      .lock_program(pv[2]), .sig_write(pv[3]), .sig_wdata(sig_wdata),
      .sig_read(pv[4]), .io_pad_out(io_pad_out), .io_pad_oe(io_pad_oe),
      .array_in(array_in), .spare_input(spare_input),
      .sleeping(sleeping), .settling(settling), .locked(locked),
      .verify_valid(verify_valid), .verify_refused(verify_refused),
      .verify_data(verify_data), .preload_refused(preload_refused),
      .sig_valid(sig_valid), .sig_data(sig_data));

   board_model board_u (
      .clock(clock), .sleep_set(sleep_set), .in_val(in_val),
      .in_drv(in_drv), .io_val(io_val), .io_drv(io_drv),
      .pad_out(io_pad_out), .pad_oe(io_pad_oe), .dev_clk(dev_clk),
      .sleep_pin(sleep_pin), .in_pad(in_pad), .io_pad(io_pad));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Registered cells show the inverted register
   function automatic logic [7:0] exp_out();
      return (cell_reg & ~m_reg) | (~cell_reg & comb_value);
   endfunction

   function automatic logic [7:0] exp_oe();
      return (cell_reg & {8{~oe_n}}) | (~cell_reg & comb_enable);
   endfunction

   task automatic chk(input string nm, input logic [63:0] e,
                      input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // One-cycle request, then a bounded wait for any answer pulse
   task automatic fire(input int k);
      @(posedge clock) pv[k] <= 1'b1;
      @(posedge clock) pv <= 5'h00;
      for (int i = 0; i < 4; i++) begin
         @(negedge clock);
         if ((verify_valid | verify_refused | preload_refused |
              sig_valid) === 1'b1) break;
      end
   endtask

   task automatic pre(input logic [7:0] mk, input logic [7:0] vl);
      @(posedge clock);
      pl_mask <= mk;
      pl_val <= vl;
      fire(0);
      chk("pl_refused", m_lock, preload_refused);
      if (!m_lock) m_reg = (m_reg & ~mk) | (vl & mk);
      cyc(2);
      chk("pad_out", exp_out(), io_pad_out);
   endtask

   task automatic verify();
      fire(1);
      chk("verify_ok", !m_lock, verify_valid);
      chk("verify_no", m_lock, verify_refused);
      chk("verify_data", m_lock ? 8'h00 : m_reg, verify_data);
   endtask

   // Valid flag and data checked apart so no bit is lost to width
   task automatic rd_sig();
      fire(4);
      chk("sig_valid", 1'h1, sig_valid);
      chk("sig", m_sig, sig_data);
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      end_sim();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      cyc(3);
      chk("settling", 1'h1, settling);
      chk("pad_out", exp_out(), io_pad_out);
      cyc(60);
      chk("settled", 1'h0, settling);
      // Device clock edges with random sums and enables
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         reg_next <= 8'($random(seed));
         comb_value <= 8'($random(seed));
         comb_enable <= 8'($random(seed));
         oe_n <= i[0];
         board_u.edge_pulse();
         if (i == 0) pre(8'hff, 8'($random(seed)));
         else m_reg = reg_next;
         cyc(2);
         chk("pad_out", exp_out(), io_pad_out);
         chk("pad_oe", exp_oe(), io_pad_oe);
      end
      pre(8'hff, 8'($random(seed)));
      pre(8'($random(seed)), 8'($random(seed)));
      verify();
      verify();
      // Sleep with every output off, then stir enables, values, sums, input pins and clock
      @(posedge clock);
      oe_n <= 1'b1;
      comb_enable <= 8'h00;
      cyc(4);
      snap = {io_pad_oe, io_pad_out};
      keep = array_in;
      @(posedge clock) sleep_set <= 1'b1;
      cyc(4);
      chk("sleeping", 1'h1, sleeping);
      @(posedge clock);
      oe_n <= 1'b0;
      comb_enable <= 8'hff;
      comb_value <= ~comb_value;
      reg_next <= ~m_reg;
      in_val <= 8'hc3;
      board_u.edge_pulse();
      fire(1);
      chk("sleep_verify", 2'h0, {verify_valid, verify_refused});
      chk("hold_pins", snap, {io_pad_oe, io_pad_out});
      chk("hold_array", keep, array_in);
      @(posedge clock) sleep_set <= 1'b0;
      cyc(5);
      chk("awake", 2'h0, {sleeping, settling});
      chk("pad_out", exp_out(), io_pad_out);
      // Pad, keeper and array stages need two more edges after wake
      cyc(2);
      chk("kept_io", exp_out(), array_in[15:8]);
      // Sleep option off: the pin is a plain input
      @(posedge clock);
      opt_en <= 1'b0;
      sleep_set <= 1'b1;
      cyc(4);
      chk("spare", 2'h2, {spare_input, sleeping});
      // Undriven input pins keep their level
      @(posedge clock);
      in_val <= 8'($random(seed));
      cyc(4);
      keep[7:0] = in_val;
      @(posedge clock) in_drv <= 8'h00;
      cyc(4);
      chk("kept_in", keep[7:0], array_in[7:0]);
      // Signature, then lock as the last programming step
      @(posedge clock) sig_wdata <= {$random(seed), $random(seed)};
      fire(3);
      m_sig = sig_wdata;
      rd_sig();
      fire(2);
      m_lock = 1'b1;
      chk("locked", 1'h1, locked);
      verify();
      pre(8'hff, ~m_reg);
      rd_sig();
      // Supply dip acts like power-up
      @(posedge clock) supply_ok <= 1'b0;
      cyc(3);
      @(posedge clock) supply_ok <= 1'b1;
      m_reg = 8'h00;
      cyc(3);
      chk("settling", 1'h1, settling);
      chk("pad_out", exp_out(), io_pad_out);
      cyc(60);
      chk("settled", 1'h0, settling);
      end_sim();
   end
endmodule

// ===== verilog/pin_keeper.sv
// Purpose: Weak keeper for one pin, retains the last driven level
// Assumes: driven is high while any driver is on the pin
// Notes:   Runs in every state, sleep included

`timescale 1ns/1ns

module pin_keeper (
   input  wire logic clock,    // System clock
   input  wire logic rst,      // Asynchronous reset, active high
   input  wire logic pad_in,   // Level seen on the pin
   input  wire logic driven,   // Some driver is active on the pin
   output logic      level     // Kept logic level
);

   // ---------------------------------------------------------------
   // Keeper state
   // ---------------------------------------------------------------
   // Follow the pin while driven, otherwise hold the old level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level <= 1'b0;
      end else if (driven) begin
         level <= pad_in;
      end
   end

   a_keeper_hold: assert property (@(posedge clock) disable iff (rst)
      !driven |=> level == $past(level))
      else $error("keeper lost its level while undriven");

   a_keeper_follow: assert property (@(posedge clock) disable iff (rst)
      driven |=> level == $past(pad_in))
      else $error("keeper did not follow the driven level");

endmodule

// ===== verilog/pld_hold_pkg.sv
// Purpose: Shared constants for the power, reset and hold control block
// Assumes: System clock of 50 MHz drives all logic
// Notes:   Timing counts are derived from times in their own units

package pld_hold_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int CELL_COUNT  = 8;   // Macrocells and their I/O pins
   localparam int INPUT_COUNT = 8;   // Dedicated logic input pins
   localparam int SIG_BITS    = 64;  // User signature width

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS  = 20;    // 50 MHz system clock
   localparam int RESET_SETTLE_NS  = 1000;  // Longest reset settle time
   // Longest time rounds down to whole cycles, never below one
   localparam int SETTLE_CYCLES    =
      (RESET_SETTLE_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
      (RESET_SETTLE_NS / CLOCK_PERIOD_NS);

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [SIG_BITS-1:0] SIG_RESET = 64'h0; // Blank signature
   localparam logic                LOCK_RESET = 1'b0;  // Unlocked part

endpackage

// ===== verilog/pld_power_reset_hold_control.sv
// Purpose: Power-up reset, sleep hold, preload and lock of a small PLD
// Assumes: All pins synchronous to clock; array logic lives outside
// Notes:   Pin clock and output enable are sampled, not used as clocks

`timescale 1ns/1ns

module pld_power_reset_hold_control
   import pld_hold_pkg::*;
#(
   parameter int N_CELLS  = CELL_COUNT,   // Macrocells
   parameter int N_INPUTS = INPUT_COUNT   // Dedicated inputs
) (
   input  wire logic                    clock,             // 50 MHz clock
   input  wire logic                    rst,               // Async reset
   input  wire logic                    supply_ok,         // Above trip
   input  wire logic                    sleep_option_en,   // Config bit
   input  wire logic                    sleep_request_pin, // Sleep pin
   input  wire logic                    dev_clk_pin,       // Common clock
   input  wire logic                    oe_n_pin,          // Common enable
   input  wire logic [N_CELLS-1:0]      cell_registered,   // Cell mode
   input  wire logic [N_CELLS-1:0]      reg_next,          // Sum terms
   input  wire logic [N_CELLS-1:0]      comb_value,        // Comb outputs
   input  wire logic [N_CELLS-1:0]      comb_enable,       // Term enables
   input  wire logic [N_INPUTS-1:0]     in_pad,            // Input pins
   input  wire logic [N_INPUTS-1:0]     in_ext_drive,      // Board drives
   input  wire logic [N_CELLS-1:0]      io_pad_in,         // I/O levels
   input  wire logic [N_CELLS-1:0]      io_ext_drive,      // Board drives
   input  wire logic                    preload_strobe,    // Preload now
   input  wire logic [N_CELLS-1:0]      preload_mask,      // Cells to load
   input  wire logic [N_CELLS-1:0]      preload_value,     // Load levels
   input  wire logic                    verify_req,        // Readback
   input  wire logic                    lock_program,      // Set lock
   input  wire logic                    sig_write,         // Store sig
   input  wire logic [SIG_BITS-1:0]     sig_wdata,         // New sig
   input  wire logic                    sig_read,          // Read sig
   output logic [N_CELLS-1:0]           io_pad_out,        // Pin drive
   output logic [N_CELLS-1:0]           io_pad_oe,         // Pin enable
   output logic [N_INPUTS+N_CELLS-1:0]  array_in,          // Array inputs
   output logic                         spare_input,       // Plain input
   output logic                         sleeping,          // In sleep
   output logic                         settling,          // In reset
   output logic                         locked,            // Lock set
   output logic                         verify_valid,      // Pulse
   output logic                         verify_refused,    // Pulse
   output logic [N_CELLS-1:0]           verify_data,       // Readback
   output logic                         preload_refused,   // Pulse
   output logic                         sig_valid,         // Pulse
   output logic [SIG_BITS-1:0]          sig_data           // Signature
);

   initial begin
      if (N_CELLS < 1 || N_INPUTS < 1) begin
         $error("cell and input counts must be at least one");
      end
   end

   // ---------------------------------------------------------------
   // Settle timer
   // ---------------------------------------------------------------
   settle_if settle ();

   // Below the trip point the timer stays cleared, like a supply still rising
   assign settle.hold = !supply_ok;

   settle_timer #(
      .CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .clock (clock),
      .rst   (rst),
      .ctl   (settle)
   );

   logic busy;
   assign busy = settle.busy;

   // ---------------------------------------------------------------
   // Pin keepers
   // ---------------------------------------------------------------
   logic [N_INPUTS-1:0] in_level;
   logic [N_CELLS-1:0]  io_level;

   // Keepers ignore sleep so idle pins never float
   genvar gi;
   generate
      for (gi = 0; gi < N_INPUTS; gi++) begin : g_in_keep
         pin_keeper u_keep (
            .clock  (clock),
            .rst    (rst),
            .pad_in (in_pad[gi]),
            .driven (in_ext_drive[gi]),
            .level  (in_level[gi])
         );
      end
      for (gi = 0; gi < N_CELLS; gi++) begin : g_io_keep
         pin_keeper u_keep (
            .clock  (clock),
            .rst    (rst),
            .pad_in (io_pad_in[gi]),
            .driven (io_ext_drive[gi] | io_pad_oe[gi]),
            .level  (io_level[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sleep state and spare input
   // ---------------------------------------------------------------
   // Sleep exists only when the option is configured
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sleeping    <= 1'b0;
         spare_input <= 1'b0;
      end else begin
         sleeping    <= sleep_option_en & sleep_request_pin;
         spare_input <= !sleep_option_en & sleep_request_pin;
      end
   end

   // Reset status seen from outside
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         settling <= 1'b1;
      end else begin
         settling <= busy;
      end
   end

   // ---------------------------------------------------------------
   // Common clock edge detect
   // ---------------------------------------------------------------
   logic clk_prev;
   logic clk_rise;

   // Previous level tracks in sleep too, so waking makes no false edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= dev_clk_pin;
      end
   end

   assign clk_rise = dev_clk_pin & ~clk_prev;

   // ---------------------------------------------------------------
   // Macrocell registers
   // ---------------------------------------------------------------
   logic [N_CELLS-1:0] mreg;
   logic [N_CELLS-1:0] next_mreg;
   logic               preload_ok;

   assign preload_ok = preload_strobe & !locked & !busy & !sleeping;

   // Preload wins over a clock edge in the same cycle
   always_comb begin
      next_mreg = mreg;
      if (busy) begin
         next_mreg = '0;
      end else if (sleeping) begin
         next_mreg = mreg;
      end else if (preload_ok) begin
         next_mreg = (mreg & ~preload_mask) |
                     (preload_value & preload_mask);
      end else if (clk_rise) begin
         next_mreg = reg_next;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mreg <= '0;
      end else begin
         mreg <= next_mreg;
      end
   end

   // ---------------------------------------------------------------
   // Output drivers
   // ---------------------------------------------------------------
   // Frozen during sleep, so a disabled pin stays disabled
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         io_pad_out <= '0;
         io_pad_oe  <= '0;
      end else if (!sleeping) begin
         for (int i = 0; i < N_CELLS; i++) begin
            if (cell_registered[i]) begin
               io_pad_out[i] <= ~next_mreg[i];
               io_pad_oe[i]  <= ~oe_n_pin;
            end else begin
               io_pad_out[i] <= comb_value[i];
               io_pad_oe[i]  <= comb_enable[i];
            end
         end
      end
   end

   // Array sees kept pin levels, blocked while asleep
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         array_in <= '0;
      end else if (!sleeping) begin
         array_in <= {io_level, in_level};
      end
   end

   // ---------------------------------------------------------------
   // Lock, verify and preload answers
   // ---------------------------------------------------------------
   // Lock is sticky; only a fresh reset models an unprogrammed part
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         locked <= LOCK_RESET;
      end else if (lock_program && !sleeping) begin
         locked <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         verify_valid    <= 1'b0;
         verify_refused  <= 1'b0;
         verify_data     <= '0;
         preload_refused <= 1'b0;
      end else begin
         verify_valid    <= verify_req & !sleeping & !locked;
         verify_refused  <= verify_req & !sleeping & locked;
         preload_refused <= preload_strobe & !sleeping & locked;
         if (verify_req && !sleeping && !locked) begin
            verify_data <= mreg;
         end else begin
            verify_data <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // User signature
   // ---------------------------------------------------------------
   logic [SIG_BITS-1:0] signature;

   // Stored while unlocked; read back regardless of lock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         signature <= SIG_RESET;
      end else if (sig_write && !locked && !sleeping) begin
         signature <= sig_wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sig_valid <= 1'b0;
         sig_data  <= '0;
      end else begin
         sig_valid <= sig_read & !sleeping;
         if (sig_read && !sleeping) begin
            sig_data <= signature;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_reset_clears: assert property (@(posedge clock) disable iff (rst)
      busy |=> mreg == '0)
      else $error("register not cleared during settle");

   a_regout_high: assert property (@(posedge clock) disable iff (rst)
      busy && !sleeping |=>
      (io_pad_out & $past(cell_registered)) == $past(cell_registered))
      else $error("registered output not high after reset");

   a_sleep_freeze: assert property (@(posedge clock) disable iff (rst)
      sleeping |=> $stable(io_pad_out) && $stable(array_in))
      else $error("outputs moved during sleep");

   a_hiz_hold: assert property (@(posedge clock) disable iff (rst)
      sleeping |=> $stable(io_pad_oe))
      else $error("output enable changed during sleep");

   a_clock_ignored: assert property (@(posedge clock) disable iff (rst)
      sleeping && !busy |=> mreg == $past(mreg))
      else $error("register changed during sleep");

   a_keeper_awake: assert property (@(posedge clock) disable iff (rst)
      sleeping && in_ext_drive[0] |=> in_level[0] == $past(in_pad[0]))
      else $error("keeper idle during sleep");

   a_plain_input: assert property (@(posedge clock) disable iff (rst)
      !sleep_option_en |=>
      !sleeping && spare_input == $past(sleep_request_pin))
      else $error("sleep pin not a plain input");

   a_preload_load: assert property (@(posedge clock) disable iff (rst)
      preload_ok |=>
      (mreg & $past(preload_mask)) ==
      ($past(preload_value) & $past(preload_mask)))
      else $error("preload did not load");

   a_lock_refuse: assert property (@(posedge clock) disable iff (rst)
      locked && verify_req && !sleeping |=>
      verify_refused && !verify_valid && verify_data == '0)
      else $error("verify not refused while locked");

   a_sig_open: assert property (@(posedge clock) disable iff (rst)
      sig_read && !sleeping && !sig_write |=>
      sig_valid && sig_data == signature)
      else $error("signature not readable");

   a_common_oe: assert property (@(posedge clock) disable iff (rst)
      !sleeping && cell_registered[0] |=> io_pad_oe[0] == !$past(oe_n_pin))
      else $error("registered cell ignores common enable");

   a_wake_resume: assert property (@(posedge clock) disable iff (rst)
      $fell(sleeping) && supply_ok && !busy |->
      mreg == $past(mreg) ##1 !busy)
      else $error("reset applied on wake");

endmodule

// ===== verilog/settle_if.sv
// Purpose: Handshake between the hold controller and its settle timer
// Assumes: Single clock domain
// Notes:   hold is a level; done is a one-cycle pulse

`timescale 1ns/1ns

interface settle_if;
   logic hold;   // Supply below trip point, keep timer cleared
   logic busy;   // Reset settle in progress
   logic done;   // Settle finished, one-cycle pulse

   modport timer (input hold, output busy, output done);
   modport user  (output hold, input busy, input done);
endinterface

// ===== verilog/settle_timer.sv
// Purpose: Counts the reset settle delay after supply becomes good
// Assumes: hold stays high while the supply is below its trip point
// Notes:   Busy from reset, so a fresh reset behaves like power-up

`timescale 1ns/1ns

module settle_timer
   import pld_hold_pkg::*;
#(
   parameter int CYCLES = SETTLE_CYCLES  // Settle length in clocks
) (
   input  wire logic clock,      // System clock
   input  wire logic rst,        // Asynchronous reset, active high
   settle_if.timer   ctl         // Hold, busy and done
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   initial begin
      if (CYCLES < 1) begin
         $error("settle_timer needs at least one cycle");
      end
   end

   logic [CW-1:0] count;

   // ---------------------------------------------------------------
   // Delay counter
   // ---------------------------------------------------------------
   // Any dip of the supply restarts the whole delay
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count    <= '0;
         ctl.busy <= 1'b1;
         ctl.done <= 1'b0;
      end else if (ctl.hold) begin
         count    <= '0;
         ctl.busy <= 1'b1;
         ctl.done <= 1'b0;
      end else if (ctl.busy) begin
         count    <= count + 1'b1;
         ctl.done <= (count == LAST);
         ctl.busy <= (count != LAST);
      end else begin
         ctl.done <= 1'b0;
      end
   end

   a_settle_length: assert property (@(posedge clock) disable iff (rst)
      $rose(ctl.busy) ##0 !ctl.hold [*1] |-> !ctl.done)
      else $error("settle ended at once");

endmodule
